// [rtl/mfc_pkg.sv]
// package for the mac flow-control and backpressure block
// assumes one 100 MHz clock; sizes in bytes, times in bit times
package mfc_pkg;

	// ==============================================================
	// register map, byte addresses, 16-bit data
	localparam logic [8:0]  REG_LOW     = 9'h1B0;
	localparam logic [8:0]  REG_HIGH    = 9'h1B2;
	localparam logic [8:0]  REG_OVR     = 9'h1B4;
	localparam logic [8:0]  REG_SIZE_A  = 9'h1B6;
	localparam logic [8:0]  REG_SIZE_B  = 9'h1B8;
	localparam logic [8:0]  REG_BACKOFF = 9'h1BA;
	localparam logic [8:0]  REG_PORT    = 9'h1BC;
	localparam logic [8:0]  REG_STATUS  = 9'h1BE;

	localparam logic [15:0] LOW_RST     = 16'h1400;
	localparam logic [15:0] HIGH_RST    = 16'h0C00;
	localparam logic [15:0] OVR_RST     = 16'h0100;
	localparam logic [15:0] PORT_RST    = 16'h0003;

	localparam int          JUMBO_BIT   = 4;
	localparam int          LONG_BIT    = 1;
	localparam int          AGGR_BIT    = 8;
	localparam int          BP_EN_BIT   = 11;
	localparam int          FDX_BIT     = 0;
	localparam int          SPD100_BIT  = 1;
	localparam logic [15:0] SIZE_A_MASK = 16'h0010;
	localparam logic [15:0] SIZE_B_MASK = 16'h0002;
	localparam logic [15:0] BO_MASK     = 16'h0100;
	localparam logic [15:0] PORT_MASK   = 16'h0803;

	// ==============================================================
	// frame sizes and timing
	localparam logic [11:0] MIN_LEN     = 12'h040;
	localparam logic [11:0] STD_MAX     = 12'h5EE;
	localparam logic [11:0] LONG_MAX    = 12'h600;
	localparam logic [11:0] JUMBO_MAX   = 12'h7D0;
	localparam logic [11:0] CTRL_LEN    = 12'h040;
	localparam logic [14:0] IPG_BITS    = 15'h0060;
	localparam logic [14:0] SLOT_BITS   = 15'h0200;
	localparam logic [14:0] PRE_BITS    = 15'h0040;
	localparam logic [8:0]  QUANT_LAST  = 9'h1FF;
	localparam logic [4:0]  MAX_TRIES   = 5'h10;
	localparam logic [4:0]  BO_LIMIT    = 5'h0A;
	localparam logic [15:0] PAUSE_MAX   = 16'hFFFF;
	localparam int          CLK_NS      = 10;
	localparam int          BIT_NS_100  = 10;
	localparam int          BIT_NS_10   = 100;
	localparam logic [3:0]  BIT_CYC_100 = 4'(BIT_NS_100 / CLK_NS);
	localparam logic [3:0]  BIT_CYC_10  = 4'(BIT_NS_10 / CLK_NS);
	localparam logic [9:0]  LFSR_SEED   = 10'h2A5;

	// ==============================================================
	// types
	typedef enum logic [1:0] {ST_GAP, ST_XMIT, ST_BACKOFF, ST_BP} mfc_state_t;

	typedef struct packed {
		logic [11:0] len;
		logic        pause;
		logic [15:0] quanta;
	} mfc_rx_info_t;

	typedef struct packed {
		logic [6:0] zero;
		logic [4:0] tries;
		logic       overrun;
		logic       backpressure;
		logic       fc_active;
		logic       paused;
	} mfc_status_t;

endpackage

// [rtl/mfc_lfsr.sv]
// pseudo-random source for back-off slot selection
// assumes it is stepped every clock; output is registered
`timescale 1ns/1ps
module mfc_lfsr (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	output logic [9:0]      rnd_out
);
	logic [9:0] lfsr_reg;
	logic [9:0] lfsr_next;

	// x^10 + x^7 + 1, maximal length
	assign lfsr_next = {lfsr_reg[8:0], lfsr_reg[9] ^ lfsr_reg[6]};

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			lfsr_reg <= mfc_pkg::LFSR_SEED;
		end else begin
			lfsr_reg <= lfsr_next;
		end
	end

	assign rnd_out = lfsr_reg;
endmodule // mfc_lfsr

// [rtl/mfc_mac.sv]
// mac transmit scheduler, receive length check, pause and backpressure
// assumes phy carrier/collision arrive async; all else on clk_in
//
// Summary of operation
// - keep 96 bit times between frames; after collision count from carrier end
// - half duplex retries with exponential back-off, drop after 16 collisions
// - drop without retry on a collision past 512 bit times
// - discard received frames shorter than 64 bytes
// - long-frame bit raises receive limit to 1536 bytes
// - jumbo bit raises receive limit to 2000 bytes
// - received pause holds next normal frame until its timer expires
// - a further pause frame reloads the running timer
// - while paused only own flow-control frames go out
// - on resource shortage send pause with maximum pause time
// - when resources free send pause with zero time
// - assert and release flow control with hysteresis
// - three programmable watermarks: low, high, overrun
// - request pause when free space falls below high watermark
// - release pause when free space rises past low watermark
// - drop received packets while free space below overrun watermark
// - backpressure follows the same conditions as pause flow control
// - during backpressure send preamble so others defer
// - periodically drop carrier briefly then raise it again
// - queued frames interrupt backpressure, then it resumes
// - collision during backpressure skips back-off, carrier held at once
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module mfc_mac #(
	parameter int BP_BURST_BITS = 4096,
	parameter int BP_GAP_BITS   = 48
) (
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	input  wire logic [8:0]            reg_addr_in,
	input  wire logic [15:0]           reg_wdata_in,
	input  wire logic                  reg_wr_in,
	input  wire logic                  reg_rd_in,
	output logic [15:0]                reg_rdata_out,
	input  wire logic                  tx_req_in,
	input  wire logic [11:0]           tx_len_in,
	output logic                       tx_done_out,
	output logic                       tx_drop_out,
	input  wire logic                  phy_crs_in,
	input  wire logic                  phy_col_in,
	output logic                       phy_tx_en_out,
	output logic                       phy_tx_pre_out,
	output logic                       tx_ctrl_out,
	output logic [15:0]                tx_quanta_out,
	input  wire logic                  rx_end_in,
	input  wire mfc_pkg::mfc_rx_info_t rx_info_in,
	output logic                       rx_accept_out,
	output logic                       rx_discard_out,
	input  wire logic [15:0]           rxq_free_in,
	output logic                       qm_drop_out,
	output logic                       fc_active_out
);
	if (BP_BURST_BITS < 2 || BP_BURST_BITS > 32767) begin : g_chk_burst
		$error("backpressure burst length out of range");
	end
	if (BP_GAP_BITS < 1 || BP_GAP_BITS >= 96) begin : g_chk_gap
		$error("backpressure gap must be shorter than the frame gap");
	end

	localparam logic [14:0] BURST_LAST = 15'(BP_BURST_BITS - 1);
	localparam logic [14:0] GAP_LAST   = 15'(BP_GAP_BITS - 1);

	// back-off window: 2^min(n,10) - 1 slots
	function automatic logic [9:0] bo_mask(input logic [4:0] n);
		logic [4:0] k;
		k = (n > mfc_pkg::BO_LIMIT) ? mfc_pkg::BO_LIMIT : n;
		return 10'((11'h001 << k) - 11'h001);
	endfunction

	// ==============================================================
	// registers
	logic [15:0] low_reg, high_reg, ovr_reg;
	logic [15:0] size_a_reg, size_b_reg, bo_reg, port_reg;
	logic [15:0] rdata_reg;
	logic        wr_low, wr_high, wr_ovr, wr_a, wr_b, wr_bo, wr_port;
	logic [15:0] rd_mux;
	mfc_pkg::mfc_status_t status;

	assign wr_low  = reg_wr_in && reg_addr_in == mfc_pkg::REG_LOW;
	assign wr_high = reg_wr_in && reg_addr_in == mfc_pkg::REG_HIGH;
	assign wr_ovr  = reg_wr_in && reg_addr_in == mfc_pkg::REG_OVR;
	assign wr_a    = reg_wr_in && reg_addr_in == mfc_pkg::REG_SIZE_A;
	assign wr_b    = reg_wr_in && reg_addr_in == mfc_pkg::REG_SIZE_B;
	assign wr_bo   = reg_wr_in && reg_addr_in == mfc_pkg::REG_BACKOFF;
	assign wr_port = reg_wr_in && reg_addr_in == mfc_pkg::REG_PORT;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			low_reg    <= mfc_pkg::LOW_RST;
			high_reg   <= mfc_pkg::HIGH_RST;
			ovr_reg    <= mfc_pkg::OVR_RST;
			size_a_reg <= 16'h0000;
			size_b_reg <= 16'h0000;
			bo_reg     <= 16'h0000;
			port_reg   <= mfc_pkg::PORT_RST;
		end else begin
			if (wr_low) low_reg <= reg_wdata_in;
			if (wr_high) high_reg <= reg_wdata_in;
			if (wr_ovr) ovr_reg <= reg_wdata_in;
			if (wr_a) size_a_reg <= reg_wdata_in & mfc_pkg::SIZE_A_MASK;
			if (wr_b) size_b_reg <= reg_wdata_in & mfc_pkg::SIZE_B_MASK;
			if (wr_bo) bo_reg <= reg_wdata_in & mfc_pkg::BO_MASK;
			if (wr_port) port_reg <= reg_wdata_in & mfc_pkg::PORT_MASK;
		end
	end

	// unmapped addresses read as zero
	assign rd_mux = (reg_addr_in == mfc_pkg::REG_LOW)     ? low_reg    :
	                (reg_addr_in == mfc_pkg::REG_HIGH)    ? high_reg   :
	                (reg_addr_in == mfc_pkg::REG_OVR)     ? ovr_reg    :
	                (reg_addr_in == mfc_pkg::REG_SIZE_A)  ? size_a_reg :
	                (reg_addr_in == mfc_pkg::REG_SIZE_B)  ? size_b_reg :
	                (reg_addr_in == mfc_pkg::REG_BACKOFF) ? bo_reg     :
	                (reg_addr_in == mfc_pkg::REG_PORT)    ? port_reg   :
	                (reg_addr_in == mfc_pkg::REG_STATUS)  ? 16'(status) : 16'h0000;

	always_ff @(posedge clk_in) begin
		if (rst_in) rdata_reg <= 16'h0000;
		else rdata_reg <= reg_rd_in ? rd_mux : 16'h0000;
	end

	logic fdx, hdx, spd100, jumbo, long_en, aggr, bp_en;
	assign fdx     = port_reg[mfc_pkg::FDX_BIT];
	assign hdx     = !fdx;
	assign spd100  = port_reg[mfc_pkg::SPD100_BIT];
	assign jumbo   = size_a_reg[mfc_pkg::JUMBO_BIT];
	assign long_en = size_b_reg[mfc_pkg::LONG_BIT];
	assign aggr    = bo_reg[mfc_pkg::AGGR_BIT];
	assign bp_en   = port_reg[mfc_pkg::BP_EN_BIT];

	// ==============================================================
	// pin synchronisers and bit-time enable
	logic crs_meta, crs_s, col_meta, col_s;
	logic [3:0] div_reg;
	logic [3:0] bit_cyc;
	logic       bit_tick;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			crs_meta <= 1'b0;
			crs_s    <= 1'b0;
			col_meta <= 1'b0;
			col_s    <= 1'b0;
		end else begin
			crs_meta <= phy_crs_in;
			crs_s    <= crs_meta;
			col_meta <= phy_col_in;
			col_s    <= col_meta;
		end
	end

	assign bit_cyc  = spd100 ? mfc_pkg::BIT_CYC_100 : mfc_pkg::BIT_CYC_10;
	assign bit_tick = (div_reg >= bit_cyc - 4'h1);

	always_ff @(posedge clk_in) begin
		if (rst_in || bit_tick) div_reg <= 4'h0;
		else div_reg <= div_reg + 4'h1;
	end

	// ==============================================================
	// receive length check, overrun drop and pause timer
	logic [11:0] max_len;
	logic        rx_ok, rx_pause_ok, paused;
	logic [15:0] pause_reg;
	logic [8:0]  quant_reg;
	logic        accept_reg, discard_reg, qm_drop_reg;

	assign max_len = jumbo ? mfc_pkg::JUMBO_MAX :
	                 long_en ? mfc_pkg::LONG_MAX : mfc_pkg::STD_MAX;
	assign rx_ok = rx_info_in.len >= mfc_pkg::MIN_LEN
	               && rx_info_in.len <= max_len && !qm_drop_reg;
	assign rx_pause_ok = rx_end_in && rx_ok && rx_info_in.pause;
	assign paused = (pause_reg != 16'h0000);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			accept_reg  <= 1'b0;
			discard_reg <= 1'b0;
			qm_drop_reg <= 1'b0;
		end else begin
			accept_reg  <= rx_end_in && rx_ok;
			discard_reg <= rx_end_in && !rx_ok;
			qm_drop_reg <= rxq_free_in < ovr_reg;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pause_reg <= 16'h0000;
			quant_reg <= 9'h000;
		end else if (rx_pause_ok) begin
			pause_reg <= rx_info_in.quanta;
			quant_reg <= 9'h000;
		end else if (paused && bit_tick) begin
			quant_reg <= quant_reg + 9'h001;
			if (quant_reg == mfc_pkg::QUANT_LAST) pause_reg <= pause_reg - 16'h0001;
		end
	end

	// ==============================================================
	// flow-control hysteresis and pause frame requests
	logic fc_reg, fc_next, fc_rise, fc_fall;
	logic on_pend, off_pend, want_ctrl, want_data, bp_want, take;

	assign fc_next = fc_reg ? !(rxq_free_in > low_reg)
	                        : (rxq_free_in < high_reg);
	assign fc_rise = fc_next && !fc_reg;
	assign fc_fall = fc_reg && !fc_next;
	assign want_ctrl = on_pend || off_pend;
	assign want_data = tx_req_in && !paused;
	assign bp_want = hdx && bp_en && fc_reg;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			fc_reg   <= 1'b0;
			on_pend  <= 1'b0;
			off_pend <= 1'b0;
		end else begin
			fc_reg   <= fc_next;
			on_pend  <= (fdx && fc_rise) || (on_pend && !take && !fc_fall);
			off_pend <= (fdx && fc_fall) || (off_pend && !take && !fc_rise);
		end
	end

	// ==============================================================
	// transmit scheduler
	mfc_pkg::mfc_state_t state_reg, state_next;
	logic [14:0] cnt_reg, cnt_next, frame_last;
	logic [9:0]  slot_reg, slot_next, rnd;
	logic [4:0]  att_reg, att_next;
	logic [11:0] len_reg, len_next;
	logic        silent_reg, silent_next, ctrl_reg, ctrl_next;
	logic        gap_done, done_evt, drop_evt;
	logic        en_reg, pre_reg, ctl_out_reg, done_reg, drop_reg;
	logic [15:0] quanta_reg;

	mfc_lfsr u_lfsr (
		.clk_in  (clk_in),
		.rst_in  (rst_in),
		.rnd_out (rnd)
	);

	assign gap_done = cnt_reg >= mfc_pkg::IPG_BITS;
	assign frame_last = mfc_pkg::PRE_BITS + {len_reg, 3'b000} - 15'h0001;
	assign take = (state_reg == mfc_pkg::ST_GAP) && (state_next == mfc_pkg::ST_XMIT)
	              && ctrl_next;

	always_comb begin
		state_next  = state_reg;
		cnt_next    = cnt_reg;
		slot_next   = slot_reg;
		att_next    = att_reg;
		len_next    = len_reg;
		silent_next = silent_reg;
		ctrl_next   = ctrl_reg;
		done_evt    = 1'b0;
		drop_evt    = 1'b0;
		case (state_reg)
		mfc_pkg::ST_GAP: begin
			if (hdx && crs_s) cnt_next = 15'h0000;
			else if (bit_tick && !gap_done) cnt_next = cnt_reg + 15'h0001;
			if (gap_done && !(hdx && crs_s)) begin
				if (want_ctrl || want_data) begin
					state_next = mfc_pkg::ST_XMIT;
					cnt_next   = 15'h0000;
					ctrl_next  = want_ctrl;
					len_next   = want_ctrl ? mfc_pkg::CTRL_LEN : tx_len_in;
				end else if (bp_want) begin
					state_next  = mfc_pkg::ST_BP;
					cnt_next    = 15'h0000;
					silent_next = 1'b0;
				end
			end
		end
		mfc_pkg::ST_XMIT: begin
			if (hdx && col_s) begin
				cnt_next = 15'h0000;
				if (cnt_reg >= mfc_pkg::SLOT_BITS) begin
					drop_evt   = 1'b1;
					att_next   = 5'h00;
					state_next = mfc_pkg::ST_GAP;
				end else if (att_reg == mfc_pkg::MAX_TRIES - 5'h01) begin
					drop_evt   = 1'b1;
					att_next   = 5'h00;
					state_next = mfc_pkg::ST_GAP;
				end else begin
					att_next = att_reg + 5'h01;
					if (bp_want) begin
						state_next  = mfc_pkg::ST_BP;
						silent_next = 1'b0;
					end else if (aggr) begin
						state_next = mfc_pkg::ST_GAP;
					end else begin
						state_next = mfc_pkg::ST_BACKOFF;
						slot_next  = rnd & bo_mask(att_reg + 5'h01);
					end
				end
			end else if (bit_tick) begin
				if (cnt_reg == frame_last) begin
					done_evt   = 1'b1;
					att_next   = 5'h00;
					cnt_next   = 15'h0000;
					state_next = mfc_pkg::ST_GAP;
				end else begin
					cnt_next = cnt_reg + 15'h0001;
				end
			end
		end
		mfc_pkg::ST_BACKOFF: begin
			if (slot_reg == 10'h000) begin
				state_next = mfc_pkg::ST_GAP;
				cnt_next   = 15'h0000;
			end else if (bit_tick) begin
				if (cnt_reg == mfc_pkg::SLOT_BITS - 15'h0001) begin
					cnt_next  = 15'h0000;
					slot_next = slot_reg - 10'h001;
				end else begin
					cnt_next = cnt_reg + 15'h0001;
				end
			end
		end
		mfc_pkg::ST_BP: begin
			if (!bp_want) begin
				state_next  = mfc_pkg::ST_GAP;
				cnt_next    = 15'h0000;
				silent_next = 1'b0;
			end else if (bit_tick) begin
				if (!silent_reg && cnt_reg == BURST_LAST) begin
					silent_next = 1'b1;
					cnt_next    = 15'h0000;
				end else if (silent_reg && cnt_reg == GAP_LAST) begin
					silent_next = 1'b0;
					cnt_next    = 15'h0000;
					if (want_data) state_next = mfc_pkg::ST_GAP;
				end else begin
					cnt_next = cnt_reg + 15'h0001;
				end
			end
		end
		default: begin
			state_next = mfc_pkg::ST_GAP;
			cnt_next   = 15'h0000;
		end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg  <= mfc_pkg::ST_GAP;
			cnt_reg    <= mfc_pkg::IPG_BITS;
			slot_reg   <= 10'h000;
			att_reg    <= 5'h00;
			len_reg    <= 12'h000;
			silent_reg <= 1'b0;
			ctrl_reg   <= 1'b0;
		end else begin
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
			slot_reg   <= slot_next;
			att_reg    <= att_next;
			len_reg    <= len_next;
			silent_reg <= silent_next;
			ctrl_reg   <= ctrl_next;
		end
	end

	// outputs follow the next state so the pins line up with state_reg
	logic bp_carrier_next;
	assign bp_carrier_next = (state_next == mfc_pkg::ST_BP) && !silent_next;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			en_reg      <= 1'b0;
			pre_reg     <= 1'b0;
			ctl_out_reg <= 1'b0;
			done_reg    <= 1'b0;
			drop_reg    <= 1'b0;
			quanta_reg  <= 16'h0000;
		end else begin
			en_reg      <= (state_next == mfc_pkg::ST_XMIT) || bp_carrier_next;
			pre_reg     <= bp_carrier_next;
			ctl_out_reg <= (state_next == mfc_pkg::ST_XMIT) && ctrl_next;
			done_reg    <= done_evt && !ctrl_reg;
			drop_reg    <= drop_evt;
			if (take) quanta_reg <= on_pend ? mfc_pkg::PAUSE_MAX : 16'h0000;
		end
	end

	assign status = '{zero: 7'h00, tries: att_reg, overrun: qm_drop_reg,
	                  backpressure: state_reg == mfc_pkg::ST_BP,
	                  fc_active: fc_reg, paused: paused};

	assign reg_rdata_out  = rdata_reg;
	assign tx_done_out    = done_reg;
	assign tx_drop_out    = drop_reg;
	assign phy_tx_en_out  = en_reg;
	assign phy_tx_pre_out = pre_reg;
	assign tx_ctrl_out    = ctl_out_reg;
	assign tx_quanta_out  = quanta_reg;
	assign rx_accept_out  = accept_reg;
	assign rx_discard_out = discard_reg;
	assign qm_drop_out    = qm_drop_reg;
	assign fc_active_out  = fc_reg;

	// ==============================================================
	// assertions
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence s_collide;
		state_reg == mfc_pkg::ST_XMIT && hdx && col_s;
	endsequence
	sequence s_bp_burst;
		state_reg == mfc_pkg::ST_BP && !silent_reg;
	endsequence

	a_gap_before_tx: assert property (
		(state_reg == mfc_pkg::ST_XMIT && $past(state_reg) == mfc_pkg::ST_GAP)
		|-> $past(cnt_reg) >= mfc_pkg::IPG_BITS)
		else $error("frame started inside the gap");
	a_drop_at_limit: assert property (
		s_collide and (att_reg == mfc_pkg::MAX_TRIES - 5'h01) |=> tx_drop_out ##1 !tx_drop_out)
		else $error("frame not dropped at collision limit");
	a_late_drop: assert property (
		s_collide and (cnt_reg >= mfc_pkg::SLOT_BITS)
		|=> tx_drop_out && state_reg == mfc_pkg::ST_GAP && att_reg == 5'h00)
		else $error("late collision retried");
	a_short_discard: assert property (
		rx_end_in && rx_info_in.len < mfc_pkg::MIN_LEN |=> rx_discard_out && !rx_accept_out)
		else $error("runt frame accepted");
	a_size_limit: assert property (
		rx_end_in && rx_info_in.len > max_len |=> !rx_accept_out)
		else $error("oversize frame accepted");
	a_pause_reload: assert property (
		rx_pause_ok |=> pause_reg == $past(rx_info_in.quanta))
		else $error("pause timer not reloaded");
	a_paused_hold: assert property (
		state_reg == mfc_pkg::ST_GAP && paused && !rx_end_in
		|=> !(state_reg == mfc_pkg::ST_XMIT && !ctrl_reg))
		else $error("data frame sent while paused");
	a_pause_max: assert property (
		take && on_pend |=> tx_ctrl_out && tx_quanta_out == mfc_pkg::PAUSE_MAX)
		else $error("pause frame without maximum time");
	a_hysteresis: assert property (
		fc_reg && rxq_free_in <= low_reg |=> fc_active_out)
		else $error("flow control released inside band");
	a_bp_carrier: assert property (
		s_bp_burst |-> phy_tx_pre_out && phy_tx_en_out)
		else $error("backpressure carrier missing");
endmodule // mfc_mac

// [verification/mfc_phy_model.sv]
// phy and link partner model: remote carrier, collisions, received frames
// assumes the mac's clock; changes its outputs just after rising edges
`timescale 1ns/1ps
module mfc_phy_model (
	input  wire logic             clk_in,
	input  wire logic             tx_en_in,
	output logic                  crs_out = 1'b0,
	output logic                  col_out = 1'b0,
	output logic                  rx_end_out = 1'b0,
	output mfc_pkg::mfc_rx_info_t rx_info_out = '0
);
	// ============
	// stimulus tasks
	task automatic rx(input logic [11:0] l, input logic p, input logic [15:0] q);
		rx_end_out <= 1'b1;
		rx_info_out <= {l, p, q};
		@(posedge clk_in);
		rx_end_out <= 1'b0;
		// details mean nothing without the strobe, so they must not linger
		rx_info_out <= ~rx_info_out;
	endtask
	// remote carrier with collision, at cycles into each of n attempts
	task automatic jam(input int n, input int at);
		repeat (n) begin
			@(posedge tx_en_in);
			repeat (at) @(posedge clk_in);
			crs_out <= 1'b1;
			col_out <= 1'b1;
			repeat (16) @(posedge clk_in);
			crs_out <= 1'b0;
			col_out <= 1'b0;
		end
	endtask
endmodule // mfc_phy_model

// [verification/mac_flow_control_backpressure_tb_top.sv]
// self-checking bench for the mac flow-control and backpressure block
// assumes mfc_pkg, mfc_mac and mfc_phy_model compiled first; 100 MHz clock
`timescale 1ns/1ps
module mac_flow_control_backpressure_tb_top;
	// ============
	// signals and event counters
	logic                  clk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0, req = 1'b0;
	logic                  done, drop, en, ctl, crs, col, rend, acc, qdrop, fca, en_q, ctl_q;
	logic                  pre, disc;
	logic [8:0]            addr = 9'h000;
	logic [11:0]           len = 12'h040;
	logic [15:0]           wdata = 16'h0000, rdata, txq, free = 16'h3000;
	mfc_pkg::mfc_rx_info_t info;
	int                    num_errors, check_count, n_start, n_done, n_drop, n_ctrl;
	int                    gap, run, last_gap, last_len;
	mfc_mac #(.BP_BURST_BITS(64), .BP_GAP_BITS(48)) dut (
		.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .tx_req_in(req),
		.tx_len_in(len), .tx_done_out(done), .tx_drop_out(drop), .phy_crs_in(crs),
		.phy_col_in(col), .phy_tx_en_out(en), .phy_tx_pre_out(pre), .tx_ctrl_out(ctl),
		.tx_quanta_out(txq), .rx_end_in(rend), .rx_info_in(info), .rx_accept_out(acc),
		.rx_discard_out(disc), .rxq_free_in(free), .qm_drop_out(qdrop), .fc_active_out(fca));
	mfc_phy_model phy (.clk_in(clk_in), .tx_en_in(en), .crs_out(crs), .col_out(col),
		.rx_end_out(rend), .rx_info_out(info));
	initial forever #5 clk_in = ~clk_in;
	// at 100M a clock is one bit time, so carrier and gap lengths count in clocks
	always @(posedge clk_in) begin
		n_done += done;
		n_drop += drop;
		n_ctrl += ctl && !ctl_q;
		n_start += en && !en_q;
		last_gap = (en && !en_q) ? gap : last_gap;
		last_len = (!en && en_q) ? run : last_len;
		gap = en ? 0 : gap + 1;
		run = en ? run + 1 : 0;
		en_q = en;
		ctl_q = ctl;
	end
	// ============
	// helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [8:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk_in);
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk_in);
		if (!w)
			chk("read data", d, rdata);
	endtask
	task automatic waitc(ref int c, input int tgt);
		for (int i = 0; i < 3000 && c < tgt; i++)
			@(posedge clk_in);
		chk("wait target reached", 1, c >= tgt);
	endtask
	// host keeps the request and length until the frame is done or dropped
	task automatic send(input logic [11:0] l);
		int k;
		k = n_done + n_drop;
		len <= l;
		req <= 1'b1;
		for (int i = 0; i < 9000 && n_done + n_drop == k; i++)
			@(posedge clk_in);
		chk("frame finished", 1, n_done + n_drop != k);
		req <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic rxck(input logic [11:0] l, input logic ok);
		phy.rx(l, 1'b0, 16'h0000);
		@(posedge clk_in);
		chk("rx accepted", ok, acc);
		chk("rx discarded", !ok, disc);
	endtask
	// ============
	// scenarios
	task automatic t_rxlen();
		logic [11:0] mx [3] = '{12'h5EE, 12'h600, 12'h7D0};
		rxck(12'h03F, 1'b0);
		rxck(12'h040, 1'b1);
		for (int m = 0; m < 3; m++) begin
			bus(1'b1, 9'h1B8, m == 1 ? 16'h0002 : 16'h0000);
			bus(1'b1, 9'h1B6, m == 2 ? 16'h0010 : 16'h0000);
			rxck(mx[m], 1'b1);
			rxck(mx[m] + 12'h001, 1'b0);
		end
	endtask
	task automatic t_tx();
		send(12'h040);
		chk("frame bits", 576, last_len);
		send(12'h040);
		chk("gap ok", 1, last_gap >= 96 && last_gap < 110);
		// at 10M a bit is ten clocks; the divider phase moves the end by up to nine
		bus(1'b1, 9'h1BC, 16'h0001);
		send(12'h040);
		chk("slow frame bits", 1, last_len >= 5751 && last_len <= 5760);
		bus(1'b1, 9'h1BC, 16'h0003);
	endtask
	task automatic t_fc();
		int c;
		c = n_ctrl;
		bus(1'b0, 9'h1B0, 16'h1400);
		bus(1'b0, 9'h1B2, 16'h0C00);
		bus(1'b0, 9'h1B4, 16'h0100);
		bus(1'b1, 9'h1B4, 16'h00C0);
		bus(1'b0, 9'h1B4, 16'h00C0);
		bus(1'b0, 9'h1C0, 16'h0000);
		free <= 16'h0BFF;
		waitc(n_ctrl, c + 1);
		chk("pause time", 16'hFFFF, txq);
		free <= 16'h1400;
		repeat (800) @(posedge clk_in);
		chk("fc held", 1, fca);
		chk("ctrl frames", c + 1, n_ctrl);
		free <= 16'h00BF;
		repeat (3) @(posedge clk_in);
		chk("overrun", 1, qdrop);
		rxck(12'h040, 1'b0);
		free <= 16'h1401;
		waitc(n_ctrl, c + 2);
		chk("release time", 16'h0000, txq);
		chk("fc off", 0, fca);
		repeat (700) @(posedge clk_in);
	endtask
	// second pause reloads; own pause frame must still get out meanwhile
	task automatic t_pause();
		int     c;
		longint t;
		phy.rx(12'h040, 1'b1, 16'h0002);
		repeat (900) @(posedge clk_in);
		phy.rx(12'h040, 1'b1, 16'h0004);
		c = n_ctrl;
		t = $time;
		free <= 16'h0BFF;
		send(12'h040);
		t = ($time - t) / 10;
		chk("held frame", 1, t >= 2112 && t < 2700);
		chk("own ctrl sent", c + 1, n_ctrl);
		free <= 16'h3000;
		waitc(n_ctrl, c + 2);
		repeat (700) @(posedge clk_in);
	endtask
	task automatic t_hdx();
		int s;
		int d;
		bus(1'b1, 9'h1BC, 16'h0002);
		s = n_start;
		fork
			phy.jam(1, 20);
			send(12'h040);
		join
		chk("backoff retry", s + 2, n_start);
		bus(1'b1, 9'h1BA, 16'h0100);
		s = n_start;
		d = n_drop;
		fork
			phy.jam(16, 20);
			send(12'h040);
		join
		chk("attempts", s + 16, n_start);
		chk("dropped", d + 1, n_drop);
		fork
			phy.jam(1, 600);
			send(12'h064);
		join
		chk("late attempts", s + 17, n_start);
		chk("late dropped", d + 2, n_drop);
	endtask
	// collision under backpressure goes straight to carrier; then bursts and silences
	task automatic t_bp();
		bus(1'b1, 9'h1BC, 16'h0802);
		fork
			phy.jam(1, 20);
			send(12'h040);
			begin
				@(posedge en);
				free <= 16'h0BFF;
				repeat (30) @(posedge clk_in);
				chk("bp after collision", 1, en && pre);
			end
		join
		repeat (120) @(posedge clk_in);
		chk("bp resumed", 1, en && pre);
		repeat (100) @(posedge clk_in);
		chk("bp burst", 64, last_len);
		chk("bp silence", 48, last_gap);
		free <= 16'h3000;
		repeat (4) @(posedge clk_in);
		chk("bp released", 0, en);
	endtask
	// ============
	// sequence, watchdog and verdict
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		t_rxlen();
		t_tx();
		t_fc();
		t_pause();
		t_hdx();
		t_bp();
		summarize();
	end
	// the full sequence needs about 19000 clocks
	initial begin
		repeat (100000) @(posedge clk_in);
		num_errors++;
		summarize();
	end
endmodule // mac_flow_control_backpressure_tb_top
